// ===== axis_motion_state_machine.sv
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/1ns
module axis_motion_state_machine #(
  parameter int POS_W = 32,
  parameter int VEL_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic drive_ready_pin,
  input wire logic home_switch_pin,
  output logic step_pulse,
  output logic step_dir,
  output logic drive_enable,
  output logic irq
);
  if (POS_W != 32 || VEL_W < 4 || VEL_W > 16)
  begin : g_bad_width
    $error("Unsupported POS_W or VEL_W");
  end

  // ==========================================================
  // Registers and pin synchronisers
  logic [motion_axis_pkg::NUM_CMD-1:0] cmd_q, cmd_prev_q;
  logic [2:0] cfg_q;
  logic [POS_W-1:0] target_par_q, dist_par_q, home_pos_q, home_ofs_q;
  logic [VEL_W-1:0] vel_par_q, max_vel_q;
  logic [7:0] dir_par_q, err_id_q;
  logic [15:0] irq_stat_q, irq_mask_q;
  logic ready_s1_q, ready_s2_q, home_s1_q, home_s2_q;
  motion_axis_pkg::axis_state_t state_q;
  logic [2:0] cur_cmd_q;
  logic signed [POS_W-1:0] pos_q, tgt_pos_q;
  logic signed [VEL_W-1:0] vel_q, vel_tgt_q;
  logic [VEL_W-1:0] acc_q;
  logic home_phase_q;
  logic [POS_W-1:0] home_cnt_q;
  logic [7:0] ramp_cnt_q;
  logic [31:0] prdata_q;
  localparam int IRQ_ERR_LSB_HOME = motion_axis_pkg::IRQ_ERR_LSB + 3;
  localparam int IRQ_ERR_LSB_VEL = motion_axis_pkg::IRQ_ERR_LSB + 2;

  logic wr_en, mapped;
  logic [motion_axis_pkg::NUM_CMD-1:0] fire, done_set, err_set;
  logic [2:0] sel;
  logic [7:0] err_code;
  logic accept, moving, allowed, limit_bad, vel_neg;
  logic [VEL_W-1:0] vmag, cur_mag;
  logic [VEL_W:0] acc_sum;
  logic move_done, halt_done, stop_done, home_load, ramp_tick;
  logic signed [POS_W-1:0] rel_tgt;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ready_s1_q <= 1'b0;
      ready_s2_q <= 1'b0;
      home_s1_q <= 1'b0;
      home_s2_q <= 1'b0;
    end
    else
    begin
      ready_s1_q <= drive_ready_pin;
      ready_s2_q <= ready_s1_q;
      home_s1_q <= home_switch_pin;
      home_s2_q <= home_s1_q;
    end
  end

  // ==========================================================
  // APB slave
  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1;
  always_comb
  begin
    unique case (paddr)
      motion_axis_pkg::OFS_CMD, motion_axis_pkg::OFS_CFG, motion_axis_pkg::OFS_TARGET,
      motion_axis_pkg::OFS_DISTANCE, motion_axis_pkg::OFS_VELOCITY,
      motion_axis_pkg::OFS_DIRECTION, motion_axis_pkg::OFS_HOME_POS,
      motion_axis_pkg::OFS_HOME_OFS, motion_axis_pkg::OFS_MAX_VEL,
      motion_axis_pkg::OFS_STATE, motion_axis_pkg::OFS_ACT_POS,
      motion_axis_pkg::OFS_IRQ_STAT, motion_axis_pkg::OFS_IRQ_MASK,
      motion_axis_pkg::OFS_ERR_ID: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_q <= '0;
      cmd_prev_q <= '0;
      cfg_q <= motion_axis_pkg::CFG_RESET;
      target_par_q <= '0;
      dist_par_q <= '0;
      vel_par_q <= '0;
      dir_par_q <= '0;
      home_pos_q <= '0;
      home_ofs_q <= '0;
      max_vel_q <= motion_axis_pkg::MAX_VEL_RESET[VEL_W-1:0];
      irq_mask_q <= motion_axis_pkg::IRQ_RESET;
    end
    else
    begin
      cmd_prev_q <= cmd_q;
      if (wr_en)
      begin
        unique case (paddr)
          motion_axis_pkg::OFS_CMD: cmd_q <= pwdata[motion_axis_pkg::NUM_CMD-1:0];
          motion_axis_pkg::OFS_CFG: cfg_q <= pwdata[2:0];
          motion_axis_pkg::OFS_TARGET: target_par_q <= pwdata;
          motion_axis_pkg::OFS_DISTANCE: dist_par_q <= pwdata;
          motion_axis_pkg::OFS_VELOCITY: vel_par_q <= pwdata[VEL_W-1:0];
          motion_axis_pkg::OFS_DIRECTION: dir_par_q <= pwdata[7:0];
          motion_axis_pkg::OFS_HOME_POS: home_pos_q <= pwdata;
          motion_axis_pkg::OFS_HOME_OFS: home_ofs_q <= pwdata;
          motion_axis_pkg::OFS_MAX_VEL: max_vel_q <= pwdata[VEL_W-1:0];
          motion_axis_pkg::OFS_IRQ_MASK: irq_mask_q <= pwdata[15:0];
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= '0;
    else if (psel && !penable)
    begin
      unique case (paddr)
        motion_axis_pkg::OFS_CMD: prdata_q <= 32'(cmd_q);
        motion_axis_pkg::OFS_CFG: prdata_q <= 32'(cfg_q);
        motion_axis_pkg::OFS_TARGET: prdata_q <= target_par_q;
        motion_axis_pkg::OFS_DISTANCE: prdata_q <= dist_par_q;
        motion_axis_pkg::OFS_VELOCITY: prdata_q <= 32'(vel_par_q);
        motion_axis_pkg::OFS_DIRECTION: prdata_q <= 32'(dir_par_q);
        motion_axis_pkg::OFS_HOME_POS: prdata_q <= home_pos_q;
        motion_axis_pkg::OFS_HOME_OFS: prdata_q <= home_ofs_q;
        motion_axis_pkg::OFS_MAX_VEL: prdata_q <= 32'(max_vel_q);
        motion_axis_pkg::OFS_STATE: prdata_q <= {16'(vel_q), 5'h00, cur_cmd_q, 5'h00, state_q};
        motion_axis_pkg::OFS_ACT_POS: prdata_q <= pos_q;
        motion_axis_pkg::OFS_IRQ_STAT: prdata_q <= 32'(irq_stat_q);
        motion_axis_pkg::OFS_IRQ_MASK: prdata_q <= 32'(irq_mask_q);
        motion_axis_pkg::OFS_ERR_ID: prdata_q <= 32'(err_id_q);
        default: prdata_q <= '0;
      endcase
    end
  end

  // ==========================================================
  // Command decode and checks
  assign fire = cmd_q & ~cmd_prev_q;
  assign vmag = vel_par_q[VEL_W-1] ? VEL_W'(-vel_par_q) : vel_par_q;
  assign cur_mag = vel_q[VEL_W-1] ? VEL_W'(-vel_q) : VEL_W'(vel_q);
  assign vel_neg = (dir_par_q == 8'h00) ? step_dir : (vel_par_q[VEL_W-1] ^ dir_par_q[7]);
  assign rel_tgt = pos_q + $signed(dist_par_q);

  always_comb
  begin
    sel = motion_axis_pkg::CMD_NONE;
    for (int i = 0; i < motion_axis_pkg::NUM_CMD; i++)
      if (fire[i])
        sel = 3'(i);
  end

  always_comb
  begin
    allowed = 1'b0;
    unique case (sel)
      motion_axis_pkg::CMD_ABS, motion_axis_pkg::CMD_REL, motion_axis_pkg::CMD_VEL,
      motion_axis_pkg::CMD_HALT:
        allowed = state_q inside {motion_axis_pkg::ST_STANDSTILL,
                                  motion_axis_pkg::ST_DISCRETE,
                                  motion_axis_pkg::ST_CONTINUOUS};
      motion_axis_pkg::CMD_HOME:
        allowed = state_q == motion_axis_pkg::ST_STANDSTILL;
      motion_axis_pkg::CMD_STOP:
        allowed = state_q != motion_axis_pkg::ST_STOPPING;
      default: allowed = 1'b0;
    endcase
  end

  assign moving = sel <= motion_axis_pkg::CMD_HOME;
  assign limit_bad = moving && ((vmag == '0) || (vmag > max_vel_q));

  always_comb
  begin
    if (!allowed)
      err_code = motion_axis_pkg::ERR_STATE;
    else if (moving && cfg_q[motion_axis_pkg::CFG_READY_CHK] && !ready_s2_q)
      err_code = motion_axis_pkg::ERR_READY;
    else if (limit_bad)
      err_code = motion_axis_pkg::ERR_LIMIT;
    else
      err_code = motion_axis_pkg::ERR_NONE;
  end
  assign accept = (sel != motion_axis_pkg::CMD_NONE) && (err_code == motion_axis_pkg::ERR_NONE);

  // ==========================================================
  // Completion conditions
  assign move_done = state_q == motion_axis_pkg::ST_DISCRETE && pos_q == tgt_pos_q
                     && (cur_cmd_q == motion_axis_pkg::CMD_ABS
                         || cur_cmd_q == motion_axis_pkg::CMD_REL);
  assign halt_done = state_q == motion_axis_pkg::ST_DISCRETE
                     && cur_cmd_q == motion_axis_pkg::CMD_HALT && vel_q == '0;
  assign stop_done = state_q == motion_axis_pkg::ST_STOPPING && vel_q == '0;
  assign home_load = state_q == motion_axis_pkg::ST_HOMING && home_phase_q
                     && home_cnt_q == home_ofs_q;

  always_comb
  begin
    done_set = '0;
    err_set = '0;
    done_set[motion_axis_pkg::CMD_ABS] = move_done && cur_cmd_q == motion_axis_pkg::CMD_ABS;
    done_set[motion_axis_pkg::CMD_REL] = move_done && cur_cmd_q == motion_axis_pkg::CMD_REL;
    done_set[motion_axis_pkg::CMD_HOME] = home_load;
    done_set[motion_axis_pkg::CMD_HALT] = halt_done;
    done_set[motion_axis_pkg::CMD_STOP] = stop_done;
    if (sel != motion_axis_pkg::CMD_NONE && !accept)
      err_set[sel] = 1'b1;
  end

  // ==========================================================
  // Axis state machine
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= motion_axis_pkg::ST_STANDSTILL;
      cur_cmd_q <= motion_axis_pkg::CMD_NONE;
      tgt_pos_q <= '0;
      vel_tgt_q <= '0;
      home_phase_q <= 1'b0;
      home_cnt_q <= '0;
    end
    else if (accept)
    begin
      cur_cmd_q <= sel;
      unique case (sel)
        motion_axis_pkg::CMD_ABS:
        begin
          state_q <= motion_axis_pkg::ST_DISCRETE;
          tgt_pos_q <= $signed(target_par_q);
          vel_tgt_q <= ($signed(target_par_q) < pos_q) ? -$signed(vmag) : $signed(vmag);
        end
        motion_axis_pkg::CMD_REL:
        begin
          state_q <= motion_axis_pkg::ST_DISCRETE;
          tgt_pos_q <= rel_tgt;
          vel_tgt_q <= (rel_tgt < pos_q) ? -$signed(vmag) : $signed(vmag);
        end
        motion_axis_pkg::CMD_VEL:
        begin
          state_q <= motion_axis_pkg::ST_CONTINUOUS;
          vel_tgt_q <= vel_neg ? -$signed(vmag) : $signed(vmag);
        end
        motion_axis_pkg::CMD_HOME:
        begin
          state_q <= motion_axis_pkg::ST_HOMING;
          home_phase_q <= 1'b0;
          home_cnt_q <= '0;
          vel_tgt_q <= cfg_q[motion_axis_pkg::CFG_HOME_NEG] ? -$signed(vmag) : $signed(vmag);
        end
        motion_axis_pkg::CMD_HALT:
        begin
          state_q <= motion_axis_pkg::ST_DISCRETE;
          vel_tgt_q <= '0;
        end
        default:
        begin
          state_q <= motion_axis_pkg::ST_STOPPING;
          vel_tgt_q <= '0;
        end
      endcase
    end
    else
    begin
      unique case (state_q)
        motion_axis_pkg::ST_DISCRETE:
          if (move_done || halt_done)
          begin
            state_q <= motion_axis_pkg::ST_STANDSTILL;
            vel_tgt_q <= '0;
          end
        motion_axis_pkg::ST_HOMING:
          if (home_load)
          begin
            state_q <= motion_axis_pkg::ST_STANDSTILL;
            vel_tgt_q <= '0;
          end
          else if (!home_phase_q)
            home_phase_q <= home_s2_q;
          else if (step_pulse)
            home_cnt_q <= home_cnt_q + 1'b1;
        motion_axis_pkg::ST_STOPPING:
          if (stop_done && !cmd_q[motion_axis_pkg::CMD_STOP])
            state_q <= motion_axis_pkg::ST_STANDSTILL;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Velocity ramp and pulse train
  assign ramp_tick = ramp_cnt_q == 8'(motion_axis_pkg::RAMP_CYCLES - 1);
  assign acc_sum = {1'b0, acc_q} + {1'b0, cur_mag};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ramp_cnt_q <= '0;
      vel_q <= '0;
    end
    else
    begin
      ramp_cnt_q <= ramp_tick ? 8'h00 : ramp_cnt_q + 8'h01;
      if (move_done || home_load)
        vel_q <= '0;
      else if (ramp_tick && vel_q < vel_tgt_q)
        vel_q <= vel_q + 1'b1;
      else if (ramp_tick && vel_q > vel_tgt_q)
        vel_q <= vel_q - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_q <= '0;
      pos_q <= '0;
      step_pulse <= 1'b0;
      step_dir <= 1'b0;
    end
    else
    begin
      acc_q <= acc_sum[VEL_W-1:0];
      step_pulse <= acc_sum[VEL_W] && !move_done;
      if (vel_q != '0)
        step_dir <= vel_q[VEL_W-1];
      if (home_load)
        pos_q <= $signed(home_pos_q);
      else if (acc_sum[VEL_W] && !move_done)
        pos_q <= vel_q[VEL_W-1] ? pos_q - 1'b1 : pos_q + 1'b1;
    end
  end

  assign drive_enable = cfg_q[motion_axis_pkg::CFG_DRV_EN];

  // ==========================================================
  // Interrupts and error identifier
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat_q <= motion_axis_pkg::IRQ_RESET;
      err_id_q <= motion_axis_pkg::ERR_NONE;
    end
    else
    begin
      irq_stat_q <= (irq_stat_q & ~((wr_en && paddr == motion_axis_pkg::OFS_IRQ_STAT)
                                    ? pwdata[15:0] : 16'h0000))
                    | {2'b00, err_set, 2'b00, done_set};
      if (err_set != '0)
        err_id_q <= err_code;
    end
  end
  assign irq = |(irq_stat_q & irq_mask_q);

  // ==========================================================
  // Assertions
  property p_stop_enter;
    @(posedge pclk) disable iff (!presetn)
    accept && sel == motion_axis_pkg::CMD_STOP |=> state_q == motion_axis_pkg::ST_STOPPING;
  endproperty
  a_stop_enter: assert property (p_stop_enter) else $error("Stop did not enter Stopping");

  property p_stop_hold;
    @(posedge pclk) disable iff (!presetn)
    state_q == motion_axis_pkg::ST_STOPPING && (cmd_q[motion_axis_pkg::CMD_STOP] || vel_q != '0)
    |=> state_q == motion_axis_pkg::ST_STOPPING;
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("Left Stopping early");

  property p_stop_exit;
    @(posedge pclk) disable iff (!presetn)
    stop_done && !cmd_q[motion_axis_pkg::CMD_STOP]
    |=> state_q == motion_axis_pkg::ST_STANDSTILL && irq_stat_q[motion_axis_pkg::CMD_STOP];
  endproperty
  a_stop_exit: assert property (p_stop_exit) else $error("Stopping exit wrong");

  property p_stopping_only_stand;
    @(posedge pclk) disable iff (!presetn)
    state_q == motion_axis_pkg::ST_STOPPING
    |=> state_q inside {motion_axis_pkg::ST_STOPPING, motion_axis_pkg::ST_STANDSTILL};
  endproperty
  a_stopping_only_stand: assert property (p_stopping_only_stand) else $error("Motion in Stopping");

  property p_wrong_state;
    @(posedge pclk) disable iff (!presetn)
    fire[motion_axis_pkg::CMD_HOME] && sel == motion_axis_pkg::CMD_HOME
    && state_q != motion_axis_pkg::ST_STANDSTILL
    |=> $stable(state_q) && irq_stat_q[IRQ_ERR_LSB_HOME];
  endproperty
  a_wrong_state: assert property (p_wrong_state) else $error("Home accepted off Standstill");

  property p_rel_capture;
    @(posedge pclk) disable iff (!presetn)
    accept && sel == motion_axis_pkg::CMD_REL
    |=> tgt_pos_q == $past(pos_q) + $signed($past(dist_par_q));
  endproperty
  a_rel_capture: assert property (p_rel_capture) else $error("Relative target wrong");

  property p_home_load;
    @(posedge pclk) disable iff (!presetn)
    home_load |=> pos_q == $signed($past(home_pos_q))
                  && state_q == motion_axis_pkg::ST_STANDSTILL;
  endproperty
  a_home_load: assert property (p_home_load) else $error("Home position not loaded");

  property p_halt_done;
    @(posedge pclk) disable iff (!presetn)
    halt_done && !accept |=> state_q == motion_axis_pkg::ST_STANDSTILL;
  endproperty
  a_halt_done: assert property (p_halt_done) else $error("Halt did not reach Standstill");

  property p_ready_reject;
    @(posedge pclk) disable iff (!presetn)
    sel == motion_axis_pkg::CMD_VEL && cfg_q[motion_axis_pkg::CFG_READY_CHK] && !ready_s2_q
    |=> (state_q != motion_axis_pkg::ST_CONTINUOUS || $past(state_q) == state_q)
        && irq_stat_q[IRQ_ERR_LSB_VEL];
  endproperty
  a_ready_reject: assert property (p_ready_reject) else $error("Moved without drive ready");
endmodule : axis_motion_state_machine

// ===== motion_axis_pkg.sv
package motion_axis_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_CFG = 8'h04;
  localparam logic [7:0] OFS_TARGET = 8'h08;
  localparam logic [7:0] OFS_DISTANCE = 8'h0C;
  localparam logic [7:0] OFS_VELOCITY = 8'h10;
  localparam logic [7:0] OFS_DIRECTION = 8'h14;
  localparam logic [7:0] OFS_HOME_POS = 8'h18;
  localparam logic [7:0] OFS_HOME_OFS = 8'h1C;
  localparam logic [7:0] OFS_MAX_VEL = 8'h20;
  localparam logic [7:0] OFS_STATE = 8'h24;
  localparam logic [7:0] OFS_ACT_POS = 8'h28;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h2C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h30;
  localparam logic [7:0] OFS_ERR_ID = 8'h34;
  // ==========================================================
  // Command trigger bit positions, ascending priority
  localparam int NUM_CMD = 6;
  localparam logic [2:0] CMD_ABS = 3'h0;
  localparam logic [2:0] CMD_REL = 3'h1;
  localparam logic [2:0] CMD_VEL = 3'h2;
  localparam logic [2:0] CMD_HOME = 3'h3;
  localparam logic [2:0] CMD_HALT = 3'h4;
  localparam logic [2:0] CMD_STOP = 3'h5;
  localparam logic [2:0] CMD_NONE = 3'h7;
  // Config bits
  localparam int CFG_READY_CHK = 0;
  localparam int CFG_DRV_EN = 1;
  localparam int CFG_HOME_NEG = 2;
  localparam logic [2:0] CFG_RESET = 3'h0;
  // Interrupt status layout and register reset values
  localparam int IRQ_ERR_LSB = 8;
  localparam logic [15:0] IRQ_RESET = 16'h0000;
  localparam logic [15:0] MAX_VEL_RESET = 16'h0100;
  // Error identifiers
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_STATE = 8'h01;
  localparam logic [7:0] ERR_READY = 8'h02;
  localparam logic [7:0] ERR_LIMIT = 8'h03;
  // ==========================================================
  // Velocity ramp timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int RAMP_TIME_NS = 1000;
  localparam int RAMP_CYCLES = (RAMP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // ==========================================================
  typedef enum logic [2:0] {
    ST_STANDSTILL,
    ST_DISCRETE,
    ST_CONTINUOUS,
    ST_HOMING,
    ST_STOPPING
  } axis_state_t;
endpackage : motion_axis_pkg

// ===== servo_drive_model.sv
`timescale 1ns/1ns
module servo_drive_model #(
  parameter int HOME_AT = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic step_pulse,
  input wire logic step_dir,
  input wire logic drive_enable,
  output logic drive_ready_pin,
  output logic home_switch_pin
);
  // ==========================================
  // Shaft position, counts steps while enabled
  logic signed [31:0] pos_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pos_q <= '0;
    end
    else if (step_pulse && drive_enable)
    begin
      pos_q <= step_dir ? pos_q - 1 : pos_q + 1;
    end
  end
  // Ready follows enable, switch past home point
  assign drive_ready_pin = drive_enable;
  assign home_switch_pin = (pos_q >= HOME_AT);
endmodule : servo_drive_model

// ===== tb_axis_motion_state_machine.sv
`timescale 1ns/1ns
module tb_axis_motion_state_machine;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, p, q;
  logic drive_ready_pin, home_switch_pin, step_pulse, step_dir, drive_enable, irq;
  int num_errors = 0;
  int compares = 0;
  axis_motion_state_machine u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .drive_ready_pin(drive_ready_pin),
    .home_switch_pin(home_switch_pin), .step_pulse(step_pulse), .step_dir(step_dir),
    .drive_enable(drive_enable), .irq(irq));
  servo_drive_model u_drive (.pclk(pclk), .presetn(presetn), .step_pulse(step_pulse),
    .step_dir(step_dir), .drive_enable(drive_enable), .drive_ready_pin(drive_ready_pin),
    .home_switch_pin(home_switch_pin));
  // ==========================================
  // Clock and helpers
  initial
  begin
    pclk = 0;
    forever #20 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic stop_test;
    if (num_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : apb
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(nm, (a == motion_axis_pkg::OFS_STATE) ? {29'h0, rd[2:0]} : rd, e);
  endtask : rdc
  task automatic cmd(input logic [31:0] v);
    apb(1, motion_axis_pkg::OFS_CMD, 32'h0000_0000);
    apb(1, motion_axis_pkg::OFS_CMD, v);
    repeat (3) @(posedge pclk);
  endtask : cmd
  task automatic wait_st(input logic [2:0] s, input int n);
    int i;
    i = 0;
    apb(0, motion_axis_pkg::OFS_STATE, 0);
    while (rd[2:0] !== s && i < n)
    begin
      apb(0, motion_axis_pkg::OFS_STATE, 0);
      i++;
    end
  endtask : wait_st
  // ==========================================
  // Scenarios
  task automatic t_reset;
    rdc("state", motion_axis_pkg::OFS_STATE, 0);
    rdc("max_vel", motion_axis_pkg::OFS_MAX_VEL, 32'h0000_0100);
    rdc("irq_stat", motion_axis_pkg::OFS_IRQ_STAT, 0);
    apb(0, 8'h3C, 0);
    chk("slverr", slv, 1);
    chk("pready", pready, 1);
  endtask : t_reset
  task automatic t_home;
    apb(1, motion_axis_pkg::OFS_CFG, 32'h0000_0002);
    chk("drive_enable", drive_enable, 1);
    apb(1, motion_axis_pkg::OFS_MAX_VEL, 32'h0000_7FFF);
    apb(1, motion_axis_pkg::OFS_VELOCITY, 32'h0000_7FFF);
    apb(1, motion_axis_pkg::OFS_HOME_POS, 32'h0000_0100);
    apb(1, motion_axis_pkg::OFS_HOME_OFS, 32'h0000_0001);
    cmd(32'h0000_0008);
    rdc("state", motion_axis_pkg::OFS_STATE, 3);
    wait_st(0, 3000);
    rdc("state", motion_axis_pkg::OFS_STATE, 0);
    rdc("act_pos", motion_axis_pkg::OFS_ACT_POS, 32'h0000_0100);
    rdc("irq_stat", motion_axis_pkg::OFS_IRQ_STAT, 32'h0000_0008);
    apb(1, motion_axis_pkg::OFS_IRQ_STAT, 32'hFFFF_FFFF);
  endtask : t_home
  task automatic t_stop;
    apb(1, motion_axis_pkg::OFS_DIRECTION, 32'h0000_00FF);
    cmd(32'h0000_0004);
    rdc("state", motion_axis_pkg::OFS_STATE, 2);
    repeat (100) @(posedge pclk);
    chk("step_dir", step_dir, 1);
    cmd(32'h0000_0008);
    rdc("state", motion_axis_pkg::OFS_STATE, 2);
    rdc("err_id", motion_axis_pkg::OFS_ERR_ID, 1);
    rdc("irq_stat", motion_axis_pkg::OFS_IRQ_STAT, 32'h0000_0800);
    apb(1, motion_axis_pkg::OFS_IRQ_STAT, 32'hFFFF_FFFF);
    cmd(32'h0000_0020);
    rdc("state", motion_axis_pkg::OFS_STATE, 4);
    apb(1, motion_axis_pkg::OFS_CMD, 32'h0000_0024);
    repeat (3) @(posedge pclk);
    rdc("state", motion_axis_pkg::OFS_STATE, 4);
    rdc("err_id", motion_axis_pkg::OFS_ERR_ID, 1);
    repeat (2000) @(posedge pclk);
    rdc("state", motion_axis_pkg::OFS_STATE, 4);
    rdc("irq_stat", motion_axis_pkg::OFS_IRQ_STAT, 32'h0000_0420);
    apb(1, motion_axis_pkg::OFS_CMD, 0);
    wait_st(0, 10);
    rdc("state", motion_axis_pkg::OFS_STATE, 0);
    apb(1, motion_axis_pkg::OFS_IRQ_STAT, 32'hFFFF_FFFF);
  endtask : t_stop
  task automatic t_halt;
    apb(1, motion_axis_pkg::OFS_DIRECTION, 32'h0000_0001);
    cmd(32'h0000_0004);
    repeat (100) @(posedge pclk);
    chk("step_dir", step_dir, 0);
    cmd(32'h0000_0010);
    rdc("state", motion_axis_pkg::OFS_STATE, 1);
    wait_st(0, 400);
    rdc("state", motion_axis_pkg::OFS_STATE, 0);
    rdc("irq_stat", motion_axis_pkg::OFS_IRQ_STAT, 32'h0000_0010);
    apb(1, motion_axis_pkg::OFS_IRQ_STAT, 32'hFFFF_FFFF);
  endtask : t_halt
  task automatic t_moves;
    apb(0, motion_axis_pkg::OFS_ACT_POS, 0);
    p = rd;
    q = u_drive.pos_q;
    apb(1, motion_axis_pkg::OFS_DISTANCE, 32'h0000_0003);
    cmd(32'h0000_0002);
    rdc("state", motion_axis_pkg::OFS_STATE, 1);
    wait_st(0, 3000);
    rdc("act_pos", motion_axis_pkg::OFS_ACT_POS, p + 3);
    chk("drive_pos", u_drive.pos_q, q + 3);
    apb(1, motion_axis_pkg::OFS_TARGET, p + 1);
    cmd(32'h0000_0001);
    wait_st(0, 3000);
    rdc("act_pos", motion_axis_pkg::OFS_ACT_POS, p + 1);
    chk("drive_pos", u_drive.pos_q, q + 1);
  endtask : t_moves
  task automatic t_err;
    apb(1, motion_axis_pkg::OFS_IRQ_STAT, 32'hFFFF_FFFF);
    apb(1, motion_axis_pkg::OFS_IRQ_MASK, 0);
    apb(1, motion_axis_pkg::OFS_VELOCITY, 0);
    cmd(32'h0000_0004);
    rdc("err_id", motion_axis_pkg::OFS_ERR_ID, 3);
    chk("irq", irq, 0);
    apb(1, motion_axis_pkg::OFS_IRQ_MASK, 32'h0000_0400);
    chk("irq", irq, 1);
    apb(1, motion_axis_pkg::OFS_IRQ_STAT, 32'h0000_0400);
    chk("irq", irq, 0);
    apb(1, motion_axis_pkg::OFS_VELOCITY, 32'h0000_7FFF);
    apb(1, motion_axis_pkg::OFS_CFG, 32'h0000_0001);
    chk("drive_enable", drive_enable, 0);
    cmd(32'h0000_0001);
    rdc("err_id", motion_axis_pkg::OFS_ERR_ID, 2);
    rdc("state", motion_axis_pkg::OFS_STATE, 0);
    apb(1, motion_axis_pkg::OFS_IRQ_STAT, 32'hFFFF_FFFF);
    cmd(32'h0000_0004);
    rdc("err_id", motion_axis_pkg::OFS_ERR_ID, 2);
    rdc("irq_stat", motion_axis_pkg::OFS_IRQ_STAT, 32'h0000_0400);
    rdc("state", motion_axis_pkg::OFS_STATE, 0);
  endtask : t_err
  // ==========================================
  // Main sequence and watchdog
  initial
  begin
    presetn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_reset();
    t_home();
    t_stop();
    t_halt();
    t_moves();
    t_err();
    stop_test();
  end
  initial
  begin
    repeat (100000) @(posedge pclk);
    num_errors++;
    stop_test();
  end
endmodule : tb_axis_motion_state_machine
